// ===== include/snsirq_pkg.sv
/*
 * Shared constants of the sensor interrupt and result update block:
 * register offsets, field positions, reset values and timing figures.
 * Assumes a 200 MHz system clock; every time constant is in microseconds.
 */
package snsirq_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets on the serial link.
   localparam logic [6:0] ADDR_DATA_FIRST = 7'h04;
   localparam logic [6:0] ADDR_DATA_LAST  = 7'h09;
   localparam logic [6:0] ADDR_STATUS     = 7'h11;
   localparam logic [6:0] ADDR_FILL_LO    = 7'h12;
   localparam logic [6:0] ADDR_FILL_HI    = 7'h13;
   localparam logic [6:0] ADDR_WTM_LO     = 7'h15;
   localparam logic [6:0] ADDR_WTM_HI     = 7'h16;
   localparam logic [6:0] ADDR_INT_CTRL   = 7'h19;
   localparam logic [6:0] ADDR_PWR        = 7'h1B;
   localparam logic [6:0] ADDR_OSR        = 7'h1C;
   localparam logic [6:0] ADDR_ODR        = 7'h1D;

   ////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int CTRL_DRIVE  = 0;
   localparam int CTRL_LEVEL  = 1;
   localparam int CTRL_LATCH  = 2;
   localparam int CTRL_WTM_EN = 3;
   localparam int CTRL_FULL_EN = 4;
   localparam int CTRL_DRDY_EN = 6;
   localparam int PWR_PRESS_EN = 0;
   localparam int PWR_TEMP_EN  = 1;
   localparam int PWR_MODE_LSB = 4;

   localparam logic [1:0] MODE_SLEEP  = 2'h0;
   localparam logic [1:0] MODE_NORMAL = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Reset values.  Pad defaults to push-pull, active high.
   localparam logic [7:0] RST_INT_CTRL = 8'h02;
   localparam logic [7:0] RST_PWR      = 8'h00;
   localparam logic [7:0] RST_OSR      = 8'h02;
   localparam logic [7:0] RST_ODR      = 8'h00;
   localparam logic [7:0] RST_WTM      = 8'h00;

   // Fill level at which the buffer counts as full (504 bytes).
   localparam logic [8:0] FULL_LEVEL = 9'h1F8;

   ////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_MHZ     = 200;
   localparam int T_BASE_US   = 234;
   localparam int T_PFIX_US   = 392;
   localparam int T_TFIX_US   = 313;
   localparam int T_OVS_US    = 2000;
   localparam int T_DRDY_US   = 2500;
   localparam int T_PERIOD_US = 5000;
   localparam int T_PULSE_US  = 1;
   localparam logic [7:0] PULSE_CYC = 8'(T_PULSE_US * CLK_MHZ);

   typedef enum logic {LNK_CMD, LNK_DATA} snsirq_lnk_t;

endpackage : snsirq_pkg

// ===== src/snsirq_sync.sv
/*
 * Two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a level or a toggle that holds for several cycles.
 */
`timescale 1ns/1ps
module snsirq_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] RSTV = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RSTV;
         q_o    <= RSTV;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule : snsirq_sync

// ===== src/snsirq_conv.sv
/*
 * Conversion timer: one start pulse begins a conversion whose length
 * follows the enabled channels and oversampling settings.
 * Assumes the start pulse comes from logic on the same clock.
 */
`timescale 1ns/1ps
module snsirq_conv #(
   parameter int unsigned BASE_CYC = 1,
   parameter int unsigned PFIX_CYC = 1,
   parameter int unsigned TFIX_CYC = 1,
   parameter int unsigned OVS_CYC  = 1
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       start_i,
   input  wire logic       press_en_i,
   input  wire logic       temp_en_i,
   input  wire logic [2:0] osr_p_i,
   input  wire logic [2:0] osr_t_i,
   output logic            busy_o,
   output logic            done_o
);

   logic [31:0] cnt_q;
   logic [31:0] total;

   always_comb begin
      total = BASE_CYC;
      if (press_en_i) begin
         total = total + PFIX_CYC + (OVS_CYC << osr_p_i);
      end
      if (temp_en_i) begin
         total = total + TFIX_CYC + (OVS_CYC << osr_t_i);
      end
   end

   // A start while busy is dropped; the running conversion goes on.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q  <= 32'h0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (!busy_o && start_i) begin
            cnt_q  <= total - 32'h1;
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (cnt_q == 32'h0) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 32'h1;
            end
         end
      end
   end

endmodule : snsirq_conv

// ===== src/snsirq_top.sv
/*
 * Sensor interrupt and result update block: serial register port,
 * interrupt flags and pad, conversion timing and result shadowing.
 * Assumes fill count and raw results come from logic on clk_sys_i and
 * that the serial clock runs only while chip select is low.
 */
`timescale 1ns/1ps
module snsirq_top
   import snsirq_pkg::*;
#(
   parameter int unsigned BASE_CYC   = T_BASE_US * CLK_MHZ,
   parameter int unsigned PFIX_CYC   = T_PFIX_US * CLK_MHZ,
   parameter int unsigned TFIX_CYC   = T_TFIX_US * CLK_MHZ,
   parameter int unsigned OVS_CYC    = T_OVS_US * CLK_MHZ,
   parameter int unsigned DRDY_CYC   = T_DRDY_US * CLK_MHZ,
   parameter int unsigned PERIOD_CYC = T_PERIOD_US * CLK_MHZ
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic        lnk_sck_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        lnk_mosi_i,
   output logic             lnk_miso_o,
   output logic             lnk_miso_oe_o,
   input  wire logic [8:0]  fill_count_i,
   input  wire logic [23:0] press_raw_i,
   input  wire logic [23:0] temp_raw_i,
   output logic             conv_busy_o,
   output logic             int_pad_o,
   output logic             int_pad_oe_o
);

   ////////////////////////////////////////////////////////////////////////
   // Link domain: byte framing on the serial clock.

   logic        lnk_rst_n;
   snsirq_lnk_t lnk_st_q;
   logic [2:0]  bit_q;
   logic [6:0]  sh_q;
   logic        rd_q;
   logic [6:0]  addr_q;
   logic [7:0]  out_q;
   logic [7:0]  byte_w;
   logic        byte_end;
   logic        req_tog_q;
   logic [6:0]  req_addr_q;
   logic        wr_tog_q;
   logic [6:0]  wr_addr_q;
   logic [7:0]  wr_data_q;
   logic [7:0]  rdata_q;

   // Chip select high holds the framing logic in reset.
   assign lnk_rst_n     = rst_n_i & ~chip_select_n_i;
   assign byte_w        = {sh_q, lnk_mosi_i};
   assign byte_end      = (bit_q == 3'h7);
   assign lnk_miso_oe_o = ~chip_select_n_i;

   always_ff @(posedge lnk_sck_i or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         lnk_st_q <= LNK_CMD;
         bit_q    <= 3'h0;
         sh_q     <= 7'h0;
         rd_q     <= 1'b0;
         addr_q   <= 7'h0;
         out_q    <= 8'h00;
      end else begin
         bit_q <= bit_q + 3'h1;
         sh_q  <= byte_w[6:0];
         if (byte_end) begin
            lnk_st_q <= LNK_DATA;
            if (lnk_st_q == LNK_CMD) begin
               rd_q   <= byte_w[7];
               addr_q <= byte_w[6:0];
            end else begin
               addr_q <= addr_q + 7'h1;
               if (rd_q) begin
                  out_q <= rdata_q;
               end
            end
         end
      end
   end

   // A read returns one dummy byte first; that byte time covers the
   // crossing of the request and the answer.  rdata_q is captured here
   // only a full byte after its request, so it stands still by then.
   always_ff @(negedge lnk_sck_i or negedge lnk_rst_n) begin
      if (!lnk_rst_n) begin
         lnk_miso_o <= 1'b0;
      end else begin
         lnk_miso_o <= out_q[3'h7 - bit_q];
      end
   end

   // Toggles survive chip select so that no false event is sent.
   always_ff @(posedge lnk_sck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_tog_q  <= 1'b0;
         req_addr_q <= 7'h0;
         wr_tog_q   <= 1'b0;
         wr_addr_q  <= 7'h0;
         wr_data_q  <= 8'h00;
      end else if (byte_end) begin
         if (lnk_st_q == LNK_CMD) begin
            if (byte_w[7]) begin
               req_tog_q  <= ~req_tog_q;
               req_addr_q <= byte_w[6:0];
            end
         end else if (rd_q) begin
            req_tog_q  <= ~req_tog_q;
            req_addr_q <= addr_q + 7'h1;
         end else begin
            wr_tog_q  <= ~wr_tog_q;
            wr_addr_q <= addr_q;
            wr_data_q <= byte_w;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Crossing into the system domain.

   logic [2:0] sync_q;
   logic       cs_p_q;
   logic       req_p_q;
   logic       wr_p_q;
   logic       cs_rise;
   logic       req_ev;
   logic       wr_ev;

   snsirq_sync #(
      .W    (3),
      .RSTV (3'h4)
   ) u_sync (
      .clk_i   (clk_sys_i),
      .rst_n_i (rst_n_i),
      .d_i     ({chip_select_n_i, req_tog_q, wr_tog_q}),
      .q_o     (sync_q)
   );

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_p_q  <= 1'b1;
         req_p_q <= 1'b0;
         wr_p_q  <= 1'b0;
      end else begin
         cs_p_q  <= sync_q[2];
         req_p_q <= sync_q[1];
         wr_p_q  <= sync_q[0];
      end
   end

   assign cs_rise = sync_q[2] & ~cs_p_q;
   assign req_ev  = sync_q[1] ^ req_p_q;
   assign wr_ev   = sync_q[0] ^ wr_p_q;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   logic [7:0] wtm_lo_q;
   logic [7:0] wtm_hi_q;
   logic       wtm_wr_q;
   logic [8:0] wtm_eff_q;
   logic [7:0] ctrl_q;
   logic [7:0] pwr_q;
   logic [7:0] osr_q;
   logic [7:0] odr_q;
   logic       conv_done;
   logic       latch;

   assign latch = ctrl_q[CTRL_LATCH];

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wtm_lo_q <= RST_WTM;
         wtm_hi_q <= RST_WTM;
         ctrl_q   <= RST_INT_CTRL;
         osr_q    <= RST_OSR;
         odr_q    <= RST_ODR;
      end else if (wr_ev) begin
         unique case (wr_addr_q)
            ADDR_WTM_LO:   wtm_lo_q <= wr_data_q;
            ADDR_WTM_HI:   wtm_hi_q <= wr_data_q;
            ADDR_INT_CTRL: ctrl_q   <= wr_data_q;
            ADDR_OSR:      osr_q    <= wr_data_q;
            ADDR_ODR:      odr_q    <= wr_data_q;
            default: ;
         endcase
      end
   end

   // both bytes land before the check
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wtm_wr_q  <= 1'b0;
         wtm_eff_q <= 9'h000;
      end else begin
         if (wr_ev && (wr_addr_q == ADDR_WTM_LO ||
                       wr_addr_q == ADDR_WTM_HI)) begin
            wtm_wr_q <= 1'b1;
         end else if (cs_rise) begin
            wtm_wr_q <= 1'b0;
         end
         if (cs_rise && wtm_wr_q) begin
            wtm_eff_q <= {wtm_hi_q[0], wtm_lo_q};
         end
      end
   end

   // A forced conversion returns the mode field to sleep when it ends.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_q <= RST_PWR;
      end else if (wr_ev && wr_addr_q == ADDR_PWR) begin
         pwr_q <= wr_data_q;
      end else if (conv_done &&
                   pwr_q[PWR_MODE_LSB +: 2] != MODE_NORMAL) begin
         pwr_q[PWR_MODE_LSB +: 2] <= MODE_SLEEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion scheduling.

   logic [47:0] per_q;
   logic        normal;
   logic        forced_q;
   logic        conv_start;
   logic [1:0]  wr_mode;

   assign normal     = (pwr_q[PWR_MODE_LSB +: 2] == MODE_NORMAL);
   assign wr_mode    = wr_data_q[PWR_MODE_LSB +: 2];
   assign conv_start = forced_q | (normal && per_q == 48'h0);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         forced_q <= 1'b0;
      end else begin
         forced_q <= wr_ev && wr_addr_q == ADDR_PWR &&
                     wr_mode != MODE_SLEEP && wr_mode != MODE_NORMAL;
      end
   end

   // period is 5 ms shifted by rate select
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         per_q <= 48'h0;
      end else if (!normal) begin
         per_q <= 48'h0;
      end else if (per_q == 48'h0) begin
         per_q <= (48'(PERIOD_CYC) << odr_q[4:0]) - 48'h1;
      end else begin
         per_q <= per_q - 48'h1;
      end
   end

   snsirq_conv #(
      .BASE_CYC (BASE_CYC),
      .PFIX_CYC (PFIX_CYC),
      .TFIX_CYC (TFIX_CYC),
      .OVS_CYC  (OVS_CYC)
   ) u_conv (
      .clk_i      (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .start_i    (conv_start),
      .press_en_i (pwr_q[PWR_PRESS_EN]),
      .temp_en_i  (pwr_q[PWR_TEMP_EN]),
      .osr_p_i    (osr_q[2:0]),
      .osr_t_i    (osr_q[5:3]),
      .busy_o     (conv_busy_o),
      .done_o     (conv_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Result registers and shadowing.

   logic [47:0] res_q;
   logic [47:0] shd_q;
   logic        pend_q;
   logic        burst_q;
   logic        data_req;

   assign data_req = req_ev && req_addr_q >= ADDR_DATA_FIRST &&
                     req_addr_q <= ADDR_DATA_LAST;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         burst_q <= 1'b0;
      end else if (cs_rise) begin
         burst_q <= 1'b0;
      end else if (data_req) begin
         burst_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         res_q  <= 48'h0;
         shd_q  <= 48'h0;
         pend_q <= 1'b0;
      end else if (conv_done && (!burst_q || cs_rise)) begin
         res_q  <= {temp_raw_i, press_raw_i};
         pend_q <= 1'b0;
      end else if (conv_done) begin
         shd_q  <= {temp_raw_i, press_raw_i};
         pend_q <= 1'b1;
      end else if (cs_rise && pend_q) begin
         // copy shadow on chip select rise
         res_q  <= shd_q;
         pend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags.

   logic       wm_cond;
   logic       full_cond;
   logic       rd_status;
   logic       wm_st_q;
   logic       full_st_q;
   logic       drdy_st_q;
   logic [2:0] data_idx;

   assign wm_cond   = wtm_eff_q != 9'h000 && fill_count_i >= wtm_eff_q;
   assign full_cond = fill_count_i >= FULL_LEVEL;
   assign rd_status = req_ev && req_addr_q == ADDR_STATUS;
   assign data_idx  = 3'(req_addr_q - ADDR_DATA_FIRST);

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wm_st_q   <= 1'b0;
         full_st_q <= 1'b0;
      end else begin
         wm_st_q   <= wm_cond | (latch & wm_st_q & ~rd_status);
         full_st_q <= full_cond | (latch & full_st_q & ~rd_status);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drdy_st_q <= 1'b0;
      end else begin
         drdy_st_q <= conv_done | (drdy_st_q & ~rd_status);
      end
   end

   // Read data for the address the link asked for.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else if (req_ev) begin
         if (data_req) begin
            rdata_q <= res_q[{data_idx, 3'h0} +: 8];
         end else begin
            unique case (req_addr_q)
               ADDR_STATUS:   rdata_q <= {4'h0, drdy_st_q, 1'b0,
                                          full_st_q, wm_st_q};
               ADDR_FILL_LO:  rdata_q <= fill_count_i[7:0];
               ADDR_FILL_HI:  rdata_q <= {7'h00, fill_count_i[8]};
               ADDR_WTM_LO:   rdata_q <= wtm_lo_q;
               ADDR_WTM_HI:   rdata_q <= wtm_hi_q;
               ADDR_INT_CTRL: rdata_q <= ctrl_q;
               ADDR_PWR:      rdata_q <= pwr_q;
               ADDR_OSR:      rdata_q <= osr_q;
               ADDR_ODR:      rdata_q <= odr_q;
               default:       rdata_q <= 8'h00;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pad contributions and pad drive.

   logic        wm_pad;
   logic        full_pad;
   logic        drdy_pad_q;
   logic        drdy_run_q;
   logic [31:0] drdy_tmr_q;
   logic        drdy_en;
   logic        int_any;
   logic        act_q;
   logic [7:0]  pulse_q;
   logic        lvl;

   assign drdy_en = ctrl_q[CTRL_DRDY_EN];

   assign wm_pad   = ctrl_q[CTRL_WTM_EN] & (latch ? wm_st_q : wm_cond);
   assign full_pad = ctrl_q[CTRL_FULL_EN] & (latch ? full_st_q : full_cond);
   assign int_any  = wm_pad | full_pad | drdy_pad_q;

   // set only at a new event
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drdy_pad_q <= 1'b0;
         drdy_run_q <= 1'b0;
         drdy_tmr_q <= 32'h0;
      end else if (conv_done && drdy_en) begin
         drdy_pad_q <= 1'b1;
         drdy_run_q <= ~latch;
         drdy_tmr_q <= DRDY_CYC - 32'h1;
      end else begin
         if (rd_status || !drdy_en ||
             (drdy_run_q && !latch && drdy_tmr_q == 32'h0)) begin
            drdy_pad_q <= 1'b0;
         end
         if (latch || drdy_tmr_q == 32'h0 || !drdy_pad_q) begin
            drdy_run_q <= 1'b0;
         end else if (drdy_run_q) begin
            drdy_tmr_q <= drdy_tmr_q - 32'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_q   <= 1'b0;
         pulse_q <= 8'h00;
      end else if (int_any && !act_q) begin
         act_q   <= 1'b1;
         pulse_q <= PULSE_CYC - 8'h01;
      end else if (pulse_q != 8'h00) begin
         pulse_q <= pulse_q - 8'h01;
      end else if (!int_any) begin
         act_q <= 1'b0;
      end
   end

   assign lvl = ctrl_q[CTRL_LEVEL] ? act_q : ~act_q;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_pad_o    <= 1'b0;
         int_pad_oe_o <= 1'b1;
      end else if (ctrl_q[CTRL_DRIVE]) begin
         int_pad_o    <= 1'b0;
         int_pad_oe_o <= ~lvl;
      end else begin
         int_pad_o    <= lvl;
         int_pad_oe_o <= 1'b1;
      end
   end

endmodule : snsirq_top

// ===== sim/snsirq_monitor.sv
/* Checker on the pad, link enable and busy ports of snsirq_top.
   Sees the top ports only; bound to every instance below. */
`timescale 1ns/1ps
module snsirq_monitor #(
   parameter int unsigned BASE_CYC = 1,
   parameter int unsigned MAX_CYC  = 4096
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic chip_select_n_i,
   input wire logic lnk_miso_oe_o,
   input wire logic conv_busy_o,
   input wire logic int_pad_o,
   input wire logic int_pad_oe_o
);
   logic [31:0] bcnt_q;
   logic        pad_w;
   // A released pad reads high through the board pull-up.
   assign pad_w = int_pad_oe_o ? int_pad_o : 1'b1;
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) bcnt_q <= '0;
      else bcnt_q <= conv_busy_o ? bcnt_q + 32'h1 : '0;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   chk_od_no_high: assert property (int_pad_o |-> int_pad_oe_o)
      else $error("pad driven high while released");
   chk_rst_pad_idle: assert property ($rose(rst_n_i) |->
      !int_pad_o && int_pad_oe_o) else $error("pad not idle");
   chk_rst_no_conv: assert property ($rose(rst_n_i) |->
      (!conv_busy_o)[*8]) else $error("busy after reset");
   chk_miso_oe_cs: assert property (lnk_miso_oe_o == !chip_select_n_i)
      else $error("miso enable off frame");
   chk_conv_min: assert property ($fell(conv_busy_o) |->
      bcnt_q + 1 >= BASE_CYC) else $error("conversion short");
   chk_conv_max: assert property (conv_busy_o |-> bcnt_q < MAX_CYC)
      else $error("conversion long");
   chk_busy_hold: assert property ($rose(conv_busy_o) |=>
      conv_busy_o[*8]) else $error("busy dropped");
   chk_pad_settle: assert property ($changed(pad_w) |=>
      $stable(pad_w)[*2]) else $error("pad glitch");
endmodule : snsirq_monitor
// The longest conversion has both channels at the top oversampling code.
bind snsirq_top snsirq_monitor #(
   .BASE_CYC (BASE_CYC),
   .MAX_CYC  (BASE_CYC + PFIX_CYC + TFIX_CYC + (OVS_CYC << 8))
) u_mon (
   .clk_sys_i, .rst_n_i, .chip_select_n_i, .lnk_miso_oe_o,
   .conv_busy_o, .int_pad_o, .int_pad_oe_o);

// ===== sim/snsirq_host.sv
/* Host model: frames serial transfers on its own 6 ns clock.
   Assumes one transfer at a time; the clock stands outside frames. */
`timescale 1ns/1ps
module snsirq_host (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   logic [7:0] rx_q [16];
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // whole burst kept in one frame
   task automatic xfer(input logic [7:0] tx [16], input int n);
      cs_n_o = 1'b0;
      #7;
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            mosi_o = tx[i][b];
            #3 sck_o = 1'b1;
            rx_q[i][b] = miso_i;
            #3 sck_o = 1'b0;
         end
      end
      #7 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #40;
   endtask : xfer
endmodule : snsirq_host

// ===== sim/snsirq_top_tb.sv
/* Self-checking bench of snsirq_top with the host model on the link.
   Fill count and raw results are driven here; the pad has a pull-up. */
`timescale 1ns/1ps
module snsirq_top_tb
   import snsirq_pkg::*;
;
   localparam int unsigned B = 20, P = 10, T = 10, O = 8, D = 300;
   localparam int TC = B + P + (O << 1) + T + O;
   logic clk_sys, rst_n, sck, cs_n, mosi, miso, miso_oe, busy, pad, pad_oe;
   logic [8:0]  fill;
   logic [23:0] praw, traw;
   logic [7:0]  tx [16];
   logic [7:0]  cv [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
   logic [1:0]  pv [4] = '{2'h3, 2'h1, 2'h2, 2'h2};
   int          err_count, check_count, blen;
   wire         pad_w = pad_oe ? pad : 1'b1;
   snsirq_top #(.BASE_CYC(B), .PFIX_CYC(P), .TFIX_CYC(T), .OVS_CYC(O),
      .DRDY_CYC(D), .PERIOD_CYC(2000)) DUT (.clk_sys_i(clk_sys),
      .rst_n_i(rst_n), .lnk_sck_i(sck), .chip_select_n_i(cs_n),
      .lnk_mosi_i(mosi), .lnk_miso_o(miso), .lnk_miso_oe_o(miso_oe),
      .fill_count_i(fill), .press_raw_i(praw), .temp_raw_i(traw),
      .conv_busy_o(busy), .int_pad_o(pad), .int_pad_oe_o(pad_oe));
   snsirq_host host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
      .miso_i(miso));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) if (busy === 1'b1) blen++;
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : wt
   task automatic wr(input logic [6:0] a, input logic [7:0] d0, d1,
      input int nb);
      wt(1);
      tx[0] = {1'b0, a};
      tx[1] = d0;
      tx[2] = d1;
      host.xfer(tx, nb + 1);
   endtask : wr
   // The first reply byte is a dummy; data starts at rx_q[2].
   task automatic rd(input logic [6:0] a, input int nb);
      wt(1);
      tx[0] = {1'b1, a};
      host.xfer(tx, nb + 2);
   endtask : rd
   task automatic conv();
      blen = 0;
      wr(ADDR_PWR, 8'h13, 8'h00, 1);
      for (int i = 0; i < 500 && busy === 1'b1; i++) wt(1);
   endtask : conv
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      fill = 9'h000;
      praw = 24'h123456;
      traw = 24'hABCDEF;
      wt(20);
      rst_n = 1'b1;
      wt(4);
      check(pad_w, 1'b0);
      rd(ADDR_INT_CTRL, 1);
      check(host.rx_q[2], RST_INT_CTRL);
      rd(7'h20, 1);
      check(host.rx_q[2], 8'h00);
      // idle pad level for each drive and polarity
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_INT_CTRL, cv[i], 8'h00, 1);
         wt(8);
         check({pad_oe, pad_w}, pv[i]);
      end
      // full event gated, flag still readable
      fill = FULL_LEVEL;
      wt(8);
      check(pad_w, 1'b0);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][1], 1'b1);
      wr(ADDR_INT_CTRL, 8'h12, 8'h00, 1);
      wt(8);
      check(pad_w, 1'b1);
      // latched full survives until read below 504
      wr(ADDR_INT_CTRL, 8'h16, 8'h00, 1);
      wt(1);
      fill = FULL_LEVEL - 9'h001;
      wt(300);
      check(pad_w, 1'b1);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][1], 1'b1);
      wt(300);
      check(pad_w, 1'b0);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][1], 1'b0);
      wr(ADDR_INT_CTRL, 8'h42, 8'h00, 1);
      wt(1);
      fill = 9'h000;
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][0], 1'b0);
      wt(1);
      fill = 9'h00A;
      wr(ADDR_WTM_LO, 8'h0A, 8'h00, 2);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][0], 1'b1);
      wr(ADDR_WTM_LO, 8'h0B, 8'h00, 2);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][0], 1'b0);
      wr(ADDR_OSR, 8'h01, 8'h00, 1);
      conv();
      check(blen + 1 >= TC && blen <= TC + 1, 1'b1);
      wt(4);
      check(pad_w, 1'b1);
      rd(ADDR_DATA_FIRST, 6);
      check({host.rx_q[4], host.rx_q[3], host.rx_q[2]}, praw);
      check({host.rx_q[7], host.rx_q[6], host.rx_q[5]}, traw);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][3], 1'b1);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][3], 1'b0);
      wt(250);
      check(pad_w, 1'b0);
      // unlatched ready pad clears itself, flag stays
      conv();
      wt(250);
      check(pad_w, 1'b1);
      wt(100);
      check(pad_w, 1'b0);
      rd(ADDR_STATUS, 1);
      check(host.rx_q[2][3], 1'b1);
      // ready pad raised latched, then unlatched: no self clear
      wr(ADDR_INT_CTRL, 8'h46, 8'h00, 1);
      conv();
      wr(ADDR_INT_CTRL, 8'h42, 8'h00, 1);
      wt(350);
      check(pad_w, 1'b1);
      rd(ADDR_STATUS, 1);
      wt(250);
      check(pad_w, 1'b0);
      // conversion ending inside a result burst
      wr(ADDR_INT_CTRL, 8'h02, 8'h00, 1);
      wt(1);
      praw = 24'h654321;
      traw = 24'h0FEDCB;
      wr(ADDR_PWR, 8'h13, 8'h00, 1);
      rd(ADDR_DATA_FIRST, 8);
      check({host.rx_q[7], host.rx_q[5], host.rx_q[2]}, 24'hABEF56);
      rd(ADDR_DATA_FIRST, 6);
      check({host.rx_q[7], host.rx_q[5], host.rx_q[2]}, 24'h0FCB21);
      // late enable keeps ready pad low
      wr(ADDR_INT_CTRL, 8'h42, 8'h00, 1);
      wt(10);
      check(pad_w, 1'b0);
      // normal mode restarts once per period shifted by rate select
      wr(ADDR_ODR, 8'h01, 8'h00, 1);
      wr(ADDR_PWR, 8'h33, 8'h00, 1);
      wt(2000);
      check(busy, 1'b0);
      wt(2000);
      check(busy, 1'b1);
      report_and_stop();
   end
endmodule : snsirq_top_tb
